// file: rtl/scs_sequencer.sv
// Top of the sampling conversion sequencer
`timescale 1ns/1ps
module scs_sequencer
	import scs_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Host control pins
	input  wire logic        chip_en,
	input  wire logic        chip_sel_n,
	input  wire logic        read_conv,
	input  wire logic        length_or_byte_select,
	input  wire logic        full_width_read,
	input  wire logic        direct_mode,
	// Analog front end
	input  wire logic        comp_above,
	output logic             hold_en,
	output logic [11:0]      dac_trial,
	// Data bus and status
	output logic [11:0]      data_out,
	output logic [11:0]      data_oe,
	output logic             conversion_busy_flag
);
	scs_sar_if sar_bus();

	scs_state_e  st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] step_len_q, step_len_d;
	logic        short_q, short_d;
	logic        sel_q, sel_d;
	logic        busy_q, busy_d;
	logic        hold_q, hold_d;
	logic [11:0] dout_q, dout_d;
	logic [11:0] oe_q, oe_d;
	logic        conv_req;
	logic        start_sar;

	// Convert request level; edges from the host sequence
	assign sel_d    = chip_en && !chip_sel_n && !read_conv;
	assign conv_req = sel_d && !sel_q;

	// Sequencing state machine
	always_comb begin
		st_d       = st_q;
		cnt_d      = cnt_q;
		step_len_d = step_len_q;
		short_d    = short_q;
		busy_d     = busy_q;
		hold_d     = hold_q;
		start_sar  = 1'b0;
		case (st_q)
			SCS_TRACK: begin
				hold_d = 1'b0;
				if (conv_req) begin // [R14]
					busy_d     = 1'b1; // [R13]
					short_d    = length_or_byte_select; // [R12]
					step_len_d = length_or_byte_select ? CNT_W'(STEP8) : CNT_W'(STEP12); // [R5]
					if (direct_mode) begin
						hold_d    = 1'b1; // [R1] [R7]
						start_sar = 1'b1;
						cnt_d     = CNT_W'(0);
						st_d      = SCS_CONV;
					end else begin
						cnt_d = CNT_W'(ACQ_CYC - 1); // [R2]
						st_d  = SCS_ACQ;
					end
				end
			end
			SCS_ACQ: begin
				if (cnt_q == CNT_W'(0)) begin // [R13]
					hold_d    = 1'b1;
					start_sar = 1'b1;
					st_d      = SCS_CONV;
				end else begin
					cnt_d = cnt_q - CNT_W'(1);
				end
			end
			SCS_CONV: begin
				if (cnt_q == step_len_q - CNT_W'(1)) begin
					cnt_d = CNT_W'(0);
				end else begin
					cnt_d = cnt_q + CNT_W'(1);
				end
				if (sar_bus.done) begin
					hold_d = 1'b0; // [R4]
					busy_d = 1'b0; // [R13]
					st_d   = SCS_TRACK;
				end
			end
			default: begin
				st_d = SCS_TRACK;
			end
		endcase
	end

	assign sar_bus.start      = start_sar;
	assign sar_bus.short_mode = short_d;
	assign sar_bus.step       = (st_q == SCS_CONV) && (cnt_q == step_len_q - CNT_W'(1));

	// Read data path and output enables
	always_comb begin
		logic rd_ok;
		rd_ok  = chip_en && !chip_sel_n && read_conv && !busy_q; // [R11]
		dout_d = 12'h000;
		oe_d   = 12'h000;
		if (rd_ok) begin
			if (full_width_read) begin
				dout_d = sar_bus.result;
				oe_d   = 12'hFFF;
			end else if (!length_or_byte_select) begin
				dout_d = {4'h0, sar_bus.result[11:4]}; // [R6]
				oe_d   = 12'h0FF;
			end else begin
				dout_d = {4'h0, sar_bus.result[3:0], LOW_PAD}; // [R6]
				oe_d   = 12'h0FF;
			end
		end
	end

	// State registers
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q       <= SCS_TRACK;
			cnt_q      <= '0;
			step_len_q <= '0;
			short_q    <= 1'b0;
			sel_q      <= 1'b0;
			busy_q     <= 1'b0;
			hold_q     <= 1'b0;
			dout_q     <= 12'h000;
			oe_q       <= 12'h000;
		end else begin
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			step_len_q <= step_len_d;
			short_q    <= short_d;
			sel_q      <= sel_d;
			busy_q     <= busy_d;
			hold_q     <= hold_d;
			dout_q     <= dout_d;
			oe_q       <= oe_d;
		end
	end

	scs_sar u_sar (
		.ref_clk    (ref_clk),
		.sys_rst    (sys_rst),
		.comp_above (comp_above),
		.bus        (sar_bus)
	);

	assign hold_en              = hold_q;
	assign dac_trial            = sar_bus.trial;
	assign data_out             = dout_q;
	assign data_oe              = oe_q;
	assign conversion_busy_flag = busy_q;

	// Assertions
	property p_direct_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		(st_q == SCS_TRACK && conv_req && direct_mode) |=> (hold_q && st_q == SCS_CONV);
	endproperty
	a_direct_hold: assert property (p_direct_hold) else $error("direct convert did not hold"); // [R1]

	property p_emul_delay;
		@(posedge ref_clk) disable iff (sys_rst)
		(st_q == SCS_TRACK && conv_req && !direct_mode) |=> !hold_q [*8];
	endproperty
	a_emul_delay: assert property (p_emul_delay) else $error("emulation held too early"); // [R2]

	property p_emul_end;
		@(posedge ref_clk) disable iff (sys_rst)
		(st_q == SCS_TRACK && conv_req && !direct_mode) |-> ##[1:41] hold_q;
	endproperty
	a_emul_end: assert property (p_emul_end) else $error("acquisition too long"); // [R2]

	property p_track_after;
		@(posedge ref_clk) disable iff (sys_rst)
		sar_bus.done |=> (!hold_q && !busy_q);
	endproperty
	a_track_after: assert property (p_track_after) else $error("no return to tracking"); // [R4]

	property p_conv_time;
		@(posedge ref_clk) disable iff (sys_rst)
		(sar_bus.start && !short_d) |-> ##[170:181] sar_bus.done;
	endproperty
	a_conv_time: assert property (p_conv_time) else $error("full conversion time wrong"); // [R5]

	property p_conv8_time;
		@(posedge ref_clk) disable iff (sys_rst)
		(sar_bus.start && short_d) |-> ##[110:121] sar_bus.done;
	endproperty
	a_conv8_time: assert property (p_conv8_time) else $error("short conversion time wrong"); // [R5]

	property p_low_byte;
		@(posedge ref_clk) disable iff (sys_rst)
		(oe_q == 12'h0FF && $past(length_or_byte_select)) |-> dout_q[3:0] == 4'h0;
	endproperty
	a_low_byte: assert property (p_low_byte) else $error("low byte padding wrong"); // [R6]

	property p_float_busy;
		@(posedge ref_clk) disable iff (sys_rst)
		$past(busy_q) |-> oe_q == 12'h000;
	endproperty
	a_float_busy: assert property (p_float_busy) else $error("outputs driven while busy"); // [R11]

	property p_busy_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		(st_q != SCS_TRACK) |-> busy_q;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early"); // [R13]

	property p_ignore;
		@(posedge ref_clk) disable iff (sys_rst)
		(st_q == SCS_CONV && !sar_bus.done) |=> st_q == SCS_CONV;
	endproperty
	a_ignore: assert property (p_ignore) else $error("conversion restarted"); // [R14]

	c_direct: cover property (@(posedge ref_clk) st_q == SCS_TRACK && conv_req && direct_mode);
	c_emul: cover property (@(posedge ref_clk) st_q == SCS_ACQ);
	c_short: cover property (@(posedge ref_clk) sar_bus.start && short_d);
	c_read: cover property (@(posedge ref_clk) oe_q != 12'h000);
endmodule

// file: rtl/scs_pkg.sv
// Package of constants and types for the sampling conversion sequencer
// Function
// [R1] Direct mode: convert command holds input and starts approximation at once.
// [R2] Emulation mode: insert acquisition delay of about 4 us before converting.
// [R3] Host allows 4 us tracking before convert in direct mode.
// [R4] Hold circuit returns to tracking immediately when conversion finishes.
// [R5] Conversion takes 18 us full length, 12 us short eight-bit.
// [R6] Byte reads: first byte bits 11..4, second bits 3..0 plus four zeros.
// [R7] Direct mode: one command both holds input and starts conversion.
// [R8] Emulation mode: host keeps input stable from command until acquisition ends.
// [R9] Direct mode: host may switch multiplexer on convert command.
// [R10] Mode select high picks direct mode, low picks emulation mode.
// [R11] Data outputs float unless read, not busy, enable high, select low.
// [R12] Convert needs read/convert low; length select low full, high short.
// [R13] Delays from clock counters; busy from command until result latched.
// [R14] Convert command ignored while a conversion is in progress.
package scs_pkg;
	localparam int unsigned CLK_HZ       = 10_000_000;
	localparam int unsigned T_ACQ_NS     = 4000;
	localparam int unsigned T_CONV12_NS  = 18000;
	localparam int unsigned T_CONV8_NS   = 12000;
	localparam int unsigned NS_PER_CLK   = 1_000_000_000 / CLK_HZ;
	localparam int unsigned ACQ_CYC      = T_ACQ_NS / NS_PER_CLK;
	localparam int unsigned CONV12_CYC   = T_CONV12_NS / NS_PER_CLK;
	localparam int unsigned CONV8_CYC    = T_CONV8_NS / NS_PER_CLK;
	localparam int unsigned RES_W        = 12;
	localparam int unsigned CNT_W        = 12;
	localparam int unsigned STEP12       = CONV12_CYC / 12;
	localparam int unsigned STEP8        = CONV8_CYC / 8;
	localparam logic [3:0]  LOW_PAD      = 4'h0;

	typedef enum logic [2:0] {
		SCS_TRACK = 3'b001,
		SCS_ACQ   = 3'b010,
		SCS_CONV  = 3'b100
	} scs_state_e;
endpackage

// file: rtl/scs_sar_if.sv
// Interface between sequencer and approximation register
`timescale 1ns/1ps
interface scs_sar_if;
	logic        start;
	logic        short_mode;
	logic        step;
	logic        done;
	logic [11:0] result;
	logic [11:0] trial;
	modport seq (output start, output short_mode, output step, input done, input result, input trial);
	modport sar (input start, input short_mode, input step, output done, output result, output trial);
endinterface

// file: rtl/scs_sar.sv
// Successive approximation register, one bit decided per step
`timescale 1ns/1ps
module scs_sar
	import scs_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// Comparator from analog front end
	input  wire logic comp_above,
	// Sequencer side
	scs_sar_if.sar    bus
);
	logic [11:0] sr_q, sr_d;
	logic [11:0] bit_q, bit_d;
	logic [11:0] res_q, res_d;
	logic        done_q, done_d;
	logic [3:0]  left_q, left_d;

	// Next value of the register
	always_comb begin
		logic [11:0] keep;
		keep   = sr_q;
		sr_d   = sr_q;
		bit_d  = bit_q;
		res_d  = res_q;
		left_d = left_q;
		done_d = 1'b0;
		if (bus.start) begin
			sr_d   = 12'h0800;
			bit_d  = 12'h0800;
			left_d = bus.short_mode ? 4'd8 : 4'd12;
		end else if (bus.step && left_q != 4'd0) begin
			keep   = comp_above ? sr_q & ~bit_q : sr_q;
			bit_d  = bit_q >> 1;
			left_d = left_q - 4'd1;
			sr_d   = (left_q == 4'd1) ? keep : (keep | (bit_q >> 1));
			if (left_q == 4'd1) begin
				res_d  = keep;
				done_d = 1'b1;
			end
		end
	end

	// Registers
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sr_q   <= 12'h0000;
			bit_q  <= 12'h0000;
			res_q  <= 12'h0000;
			left_q <= 4'd0;
			done_q <= 1'b0;
		end else begin
			sr_q   <= sr_d;
			bit_q  <= bit_d;
			res_q  <= res_d;
			left_q <= left_d;
			done_q <= done_d;
		end
	end

	assign bus.trial  = sr_q;
	assign bus.result = res_q;
	assign bus.done   = done_q;
endmodule

// file: dv/scs_front_model.sv
// Behavioural analog front end: hold capacitor and comparator
`timescale 1ns/1ps
module scs_front_model (
	// Clock
	input  wire logic        ref_clk,
	// Analog side
	input  wire logic [11:0] vin,
	input  wire logic        hold_en,
	input  wire logic [11:0] dac_trial,
	output logic             comp_above
);
	logic [11:0] held_q;

	// Capacitor follows the input while tracking and freezes once hold is raised
	always_ff @(posedge ref_clk) begin
		if (!hold_en) begin
			held_q <= vin;
		end
	end

	// Comparator flags a trial code above the held sample
	assign comp_above = (dac_trial > held_q);
endmodule

// file: dv/sampling_conversion_sequencer_tb.sv
// Self-checking bench for the sampling conversion sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fails++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module sampling_conversion_sequencer_tb;
	import scs_pkg::*;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        chip_en = 1'b0;
	logic        chip_sel_n = 1'b1;
	logic        read_conv = 1'b1;
	logic        length_or_byte_select = 1'b0;
	logic        full_width_read = 1'b1;
	logic        direct_mode = 1'b1;
	logic [11:0] vin = 12'h000;
	logic        comp_above;
	logic        hold_en;
	logic        conversion_busy_flag;
	logic [11:0] dac_trial;
	logic [11:0] data_out;
	logic [11:0] data_oe;
	int          fails = 0;
	int          n_checks = 0;
	int          cycles = 0;

	scs_sequencer scs_sequencer_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .chip_en(chip_en),
		.chip_sel_n(chip_sel_n), .read_conv(read_conv), .length_or_byte_select(length_or_byte_select),
		.full_width_read(full_width_read), .direct_mode(direct_mode), .comp_above(comp_above),
		.hold_en(hold_en), .dac_trial(dac_trial), .data_out(data_out), .data_oe(data_oe),
		.conversion_busy_flag(conversion_busy_flag));
	scs_front_model scs_front_model_inst (.ref_clk(ref_clk), .vin(vin), .hold_en(hold_en),
		.dac_trial(dac_trial), .comp_above(comp_above));

	// Clock of 100 ns period
	always #50 ref_clk = ~ref_clk;

	// Prints the counts and the verdict, then stops
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles > 5000) begin
			fails++;
			give_verdict();
		end
	end

	// One conversion; the input moves after hold and a second command lands mid-conversion
	task automatic conv(input logic dm, input logic sh, input logic [11:0] v);
		int cyc;
		int hcyc;
		int ex_cyc;
		direct_mode <= dm;
		vin <= v;
		repeat (ACQ_CYC + 2) @(posedge ref_clk);
		length_or_byte_select <= sh;
		chip_en <= 1'b1;
		chip_sel_n <= 1'b0;
		read_conv <= 1'b0;
		full_width_read <= 1'b1;
		@(posedge ref_clk);
		read_conv <= 1'b1;
		cyc = 0;
		hcyc = -1;
		do begin
			@(posedge ref_clk);
			read_conv <= (cyc != 60);
			if (hcyc > 0) vin <= ~v;
			#1;
			cyc++;
			if (hold_en === 1'b1 && hcyc < 0) begin
				hcyc = cyc;
				`CHK("first_trial", 12'h800, dac_trial)
			end
			if (cyc == 10) `CHK("oe_while_busy", 12'h000, data_oe)
		end while ((conversion_busy_flag === 1'b1 || cyc < 3) && cyc < 400);
		ex_cyc = (dm ? 0 : ACQ_CYC) + (sh ? CONV8_CYC : CONV12_CYC);
		`CHK("busy_length", 1'b1, (cyc >= ex_cyc && cyc <= ex_cyc + 6))
		`CHK("hold_start", 1'b1, (dm ? (hcyc == 1 || hcyc == 2) : (hcyc >= ACQ_CYC && hcyc <= ACQ_CYC + 2)))
		`CHK("hold_release", 1'b0, hold_en)
		$display("conversion done direct=%0b short=%0b cycles=%0d", dm, sh, cyc);
	endtask

	// One read cycle, then the bus must float again
	task automatic rd(input logic fw, input logic bs, input logic [11:0] exd, input logic [11:0] exo);
		@(posedge ref_clk);
		chip_en <= 1'b1;
		chip_sel_n <= 1'b0;
		read_conv <= 1'b1;
		full_width_read <= fw;
		length_or_byte_select <= bs;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK("read_oe", exo, data_oe)
		`CHK("read_data", exd, data_out & exo)
		@(posedge ref_clk);
		chip_en <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK("float_oe", 12'h000, data_oe)
		$display("read done full=%0b byte=%0b", fw, bs);
	endtask

	// Reset in mid conversion must abort it; the block comes back idle and tracking
	task automatic rst_mid();
		direct_mode <= 1'b1;
		vin <= 12'h5A5;
		repeat (ACQ_CYC + 2) @(posedge ref_clk);
		length_or_byte_select <= 1'b0;
		chip_en <= 1'b1;
		chip_sel_n <= 1'b0;
		read_conv <= 1'b0;
		@(posedge ref_clk);
		read_conv <= 1'b1;
		repeat (20) @(posedge ref_clk);
		#1;
		`CHK("mid_busy", 1'b1, conversion_busy_flag)
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		chip_en <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK("rst_busy", 1'b0, conversion_busy_flag)
		`CHK("rst_hold", 1'b0, hold_en)
		`CHK("rst_oe", 12'h000, data_oe)
		@(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK("rel_busy", 1'b0, conversion_busy_flag)
		`CHK("rel_hold", 1'b0, hold_en)
		$display("reset in mid conversion done");
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		conv(1'b1, 1'b0, 12'hA5C);
		rd(1'b1, 1'b0, 12'hA5C, 12'hFFF);
		rd(1'b0, 1'b0, 12'h0A5, 12'h0FF);
		rd(1'b0, 1'b1, 12'h0C0, 12'h0FF);
		rst_mid();
		conv(1'b1, 1'b1, 12'h3C7);
		rd(1'b0, 1'b0, 12'h03C, 12'h0FF);
		conv(1'b0, 1'b0, 12'h801);
		rd(1'b0, 1'b1, 12'h010, 12'h0FF);
		rd(1'b1, 1'b0, 12'h801, 12'hFFF);
		conv(1'b0, 1'b1, 12'hFFF);
		rd(1'b0, 1'b0, 12'h0FF, 12'h0FF);
		conv(1'b1, 1'b0, 12'h000);
		rd(1'b1, 1'b0, 12'h000, 12'hFFF);
		give_verdict();
	end
endmodule
